//--- hw/sac_pkg.sv
package sac_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] RESULT0_OFS      = 8'h00;
  localparam logic [7:0] RESULT7_OFS      = 8'h1c;
  localparam logic [7:0] CONV_CONTROL_OFS = 8'h20;
  localparam logic [7:0] CHAN_ENABLE_OFS  = 8'h24;
  localparam logic [7:0] COMPARE_OFS      = 8'h28;
  localparam logic [7:0] CONV_STATUS_OFS  = 8'h30;
  localparam logic [7:0] CALIB_CONTROL_OFS = 8'h34;
  localparam logic [7:0] CLOCK_SOURCE_OFS = 8'h38;
  localparam logic [7:0] CLOCK_DIVIDE_OFS = 8'h3c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RES_VALID_BIT  = 17;
  localparam int RES_OVR_BIT    = 16;
  localparam int CTL_IRQEN_BIT  = 1;
  localparam int CTL_MODE_LSB   = 2;
  localparam int CTL_TRGC_LSB   = 6;
  localparam int CTL_TRGEN_BIT  = 8;
  localparam int CTL_DIFF_BIT   = 10;
  localparam int CTL_START_BIT  = 11;
  localparam int CHE_BGAP_BIT   = 8;
  localparam int CMP_EN_BIT     = 0;
  localparam int CMP_IE_BIT     = 1;
  localparam int CMP_COND_BIT   = 2;
  localparam int CMP_CH_LSB     = 3;
  localparam int CMP_CNT_LSB    = 8;
  localparam int CMP_VAL_LSB    = 16;
  localparam int STS_END_BIT    = 0;
  localparam int STS_CMP_BIT    = 1;
  localparam int STS_BUSY_BIT   = 2;
  localparam int STS_CHAN_LSB   = 4;
  localparam int STS_FCNT_LSB   = 8;
  localparam int CAL_EN_BIT     = 0;
  localparam int CAL_DONE_BIT   = 1;

  // ---------------------------------------------------------------
  // Sizes, counts, reset values
  // ---------------------------------------------------------------
  localparam int         RES_W        = 12;
  localparam int         NUM_CH       = 8;
  localparam logic [7:0] DIFF_CH_MASK = 8'h0f;
  localparam logic [6:0] CAL_TICKS    = 7'h7f;
  localparam logic [3:0] FIFO_DEPTH   = 4'h8;
  localparam logic [3:0] FIFO_FLAG_AT = 4'h4;

  typedef enum logic [1:0] {
    SAC_SINGLE = 2'b00,
    SAC_BURST  = 2'b01,
    SAC_SSCAN  = 2'b10,
    SAC_CSCAN  = 2'b11
  } sac_mode_e;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CAL  = 2'b01,
    SAC_REQ  = 2'b10,
    SAC_WAIT = 2'b11
  } sac_state_e;

endpackage

//--- hw/sac_ctrl.sv
// How it works
// - One converter, 12-bit results, eight selectable input channels.
// - Four modes: single, burst, single-cycle scan, continuous scan.
// - Start by software writing the start bit or by trigger pin edge.
// - Calibration enable runs 127 converter clocks, then sets calibration done.
// - Converter clock: one of three sources, divided by prescaler plus one.
// - Single mode converts once into that channel's result register.
// - Single-mode end sets end flag; interrupt when enabled.
// - Single mode: start bit reads one, hardware clears it at end.
// - Single mode uses only the lowest enabled channel.
// - Burst converts one channel repeatedly into an 8-deep FIFO at result 0.
// - Burst sets end flag once FIFO holds more than four samples.
// - Burst runs while start bit set; clearing it returns to idle.
// - Burst uses only the lowest enabled channel.
// - Single-cycle scan converts every enabled channel once, ascending.
// - Continuous scan repeats the ascending scan until stopped.
// - Channel 7 selects external pin or internal bandgap.
// - Eight single-ended channels or four differential pairs.
// - Each result register carries valid and overrun indicators.
// - Results compared with programmed value; optional match interrupt.
// - Unread result replaced sets overrun; a read clears overrun, and valid once no unread sample remains.
module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     extTrigPin,
  input  wire logic                     extClkPin,
  input  wire logic                     anaDone,
  input  wire logic [sac_pkg::RES_W-1:0] anaResult,
  output logic                          anaStart,
  output logic      [2:0]               anaChan,
  output logic                          anaCalib,
  output logic                          anaDiff,
  output logic                          anaBandgap,
  output logic                          convClkEn,
  output logic                          convIrq
);
  import sac_pkg::*;

  typedef struct packed {
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic [2:0]                trigSync;
    logic [2:0]                eclkSync;
    logic                      halfTog;
    logic [7:0]                divCnt;
    logic                      tick;
    logic [1:0]                clock_source_reg;
    logic [7:0]                clock_divide_reg;
    logic                      irqEn;
    logic [1:0]                mode;
    logic [1:0]                trgCond;
    logic                      trgEn;
    logic                      diffMode;
    logic                      startBit;
    logic [7:0]                chanEn;
    logic                      bandgap;
    logic                      cmpEn;
    logic                      cmpIe;
    logic                      cmpCond;
    logic [2:0]                cmpCh;
    logic [3:0]                cmpCnt;
    logic [RES_W-1:0]          cmpVal;
    logic [3:0]                matchCnt;
    logic                      endFlag;
    logic                      cmpFlag;
    logic                      calReq;
    logic                      calDone;
    logic [6:0]                calCnt;
    logic                      calRun;
    sac_state_e                state;
    logic [2:0]                chan;
    logic                      anaStart;
    logic                      irq;
    logic [NUM_CH-1:0][RES_W-1:0] res;
    logic [NUM_CH-1:0]         resValid;
    logic [NUM_CH-1:0]         resOvr;
    logic [7:0][RES_W-1:0]     fifo;
    logic [2:0]                fifoRd;
    logic [2:0]                fifoWr;
    logic [3:0]                fifoCnt;
    logic                      fifoOvr;
  } sac_state_s;

  sac_state_s q;
  sac_state_s d;

  // Lowest enabled channel at or above a start index
  function automatic logic [3:0] sac_find(input logic [7:0] mask, input logic [3:0] from);
    logic [3:0] hit;
    hit = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= from)) begin
        hit = {1'b1, 3'(i)};
      end
    end
    return hit;
  endfunction

  logic [7:0]  effMask;
  logic [3:0]  firstCh;
  logic [3:0]  nextCh;
  logic        acc;
  logic        wrEn;
  logic        rdEn;
  logic        doneEv;
  logic        srcTick;
  logic        trigEdge;
  logic        cmpMatch;
  logic [4:0]  cntInc;

  // Differential operation leaves only four pairs
  assign effMask  = q.chanEn & (q.diffMode ? DIFF_CH_MASK : 8'hff);
  assign firstCh  = sac_find(effMask, 4'h0);
  assign nextCh   = sac_find(effMask, {1'b0, q.chan} + 4'h1);
  assign acc      = psel & penable;
  assign wrEn     = acc & q.pready & pwrite;
  assign rdEn     = acc & q.pready & ~pwrite;
  assign doneEv   = (q.state == SAC_WAIT) & anaDone;
  assign trigEdge = (q.trgCond[0] ? (q.trigSync[1] & ~q.trigSync[2])
                                  : (~q.trigSync[1] & q.trigSync[2]));
  assign cmpMatch = q.cmpCond ? (anaResult >= q.cmpVal) : (anaResult < q.cmpVal);
  assign cntInc   = {1'b0, q.matchCnt} + 5'h01;

  // ---------------------------------------------------------------
  // Converter clock source and prescaler
  // ---------------------------------------------------------------
  always_comb begin
    case (q.clock_source_reg)
      2'b01:   srcTick = q.halfTog;
      2'b10:   srcTick = q.eclkSync[1] & ~q.eclkSync[2];
      default: srcTick = 1'b1;
    endcase
  end

  always_comb begin
    d = q;
    d.anaStart = 1'b0;
    d.tick     = 1'b0;
    d.trigSync = {q.trigSync[1:0], extTrigPin};
    d.eclkSync = {q.eclkSync[1:0], extClkPin};
    d.halfTog  = ~q.halfTog;
    if (srcTick) begin
      if (q.divCnt >= q.clock_divide_reg) begin
        d.divCnt = 8'h00;
        d.tick   = 1'b1;
      end else begin
        d.divCnt = q.divCnt + 8'h01;
      end
    end

    // ---------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // ---------------------------------------------------------------
    d.pready = acc & ~q.pready;
    if (acc & ~q.pready) begin
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      if (paddr[1:0] != 2'b00) begin
        d.pslverr = 1'b1;
      end else if (paddr <= RESULT7_OFS) begin
        if (paddr == RESULT0_OFS && q.mode == SAC_BURST) begin
          d.prdata[RES_VALID_BIT] = q.fifoCnt != 4'h0;
          d.prdata[RES_OVR_BIT]   = q.fifoOvr;
          d.prdata[RES_W-1:0]     = q.fifo[q.fifoRd];
        end else begin
          d.prdata[RES_VALID_BIT] = q.resValid[paddr[4:2]];
          d.prdata[RES_OVR_BIT]   = q.resOvr[paddr[4:2]];
          d.prdata[RES_W-1:0]     = q.res[paddr[4:2]];
        end
      end else if (paddr == CONV_CONTROL_OFS) begin
        d.prdata[CTL_IRQEN_BIT]                 = q.irqEn;
        d.prdata[CTL_MODE_LSB+:2]               = q.mode;
        d.prdata[CTL_TRGC_LSB+:2]               = q.trgCond;
        d.prdata[CTL_TRGEN_BIT]                 = q.trgEn;
        d.prdata[CTL_DIFF_BIT]                  = q.diffMode;
        d.prdata[CTL_START_BIT]                 = q.startBit;
      end else if (paddr == CHAN_ENABLE_OFS) begin
        d.prdata[7:0]          = q.chanEn;
        d.prdata[CHE_BGAP_BIT] = q.bandgap;
      end else if (paddr == COMPARE_OFS) begin
        d.prdata[CMP_EN_BIT]         = q.cmpEn;
        d.prdata[CMP_IE_BIT]         = q.cmpIe;
        d.prdata[CMP_COND_BIT]       = q.cmpCond;
        d.prdata[CMP_CH_LSB+:3]      = q.cmpCh;
        d.prdata[CMP_CNT_LSB+:4]     = q.cmpCnt;
        d.prdata[CMP_VAL_LSB+:RES_W] = q.cmpVal;
      end else if (paddr == CONV_STATUS_OFS) begin
        d.prdata[STS_END_BIT]    = q.endFlag;
        d.prdata[STS_CMP_BIT]    = q.cmpFlag;
        d.prdata[STS_BUSY_BIT]   = q.state != SAC_IDLE;
        d.prdata[STS_CHAN_LSB+:3] = q.chan;
        d.prdata[STS_FCNT_LSB+:4] = q.fifoCnt;
      end else if (paddr == CALIB_CONTROL_OFS) begin
        d.prdata[CAL_EN_BIT]   = q.calReq;
        d.prdata[CAL_DONE_BIT] = q.calDone;
      end else if (paddr == CLOCK_SOURCE_OFS) begin
        d.prdata[1:0] = q.clock_source_reg;
      end else if (paddr == CLOCK_DIVIDE_OFS) begin
        d.prdata[7:0] = q.clock_divide_reg;
      end else begin
        d.pslverr = 1'b1;
      end
    end

    // Reads of results clear the indicators; a store below wins
    if (rdEn && paddr <= RESULT7_OFS && paddr[1:0] == 2'b00) begin
      if (paddr == RESULT0_OFS && q.mode == SAC_BURST) begin
        if (q.fifoCnt != 4'h0) begin
          d.fifoRd  = q.fifoRd + 3'h1;
          d.fifoCnt = q.fifoCnt - 4'h1;
        end
        d.fifoOvr = 1'b0;
      end else begin
        d.resValid[paddr[4:2]] = 1'b0;
        d.resOvr[paddr[4:2]]   = 1'b0;
      end
    end

    if (wrEn) begin
      if (paddr == CONV_CONTROL_OFS) begin
        d.irqEn    = pwdata[CTL_IRQEN_BIT];
        d.mode     = pwdata[CTL_MODE_LSB+:2];
        d.trgCond  = pwdata[CTL_TRGC_LSB+:2];
        d.trgEn    = pwdata[CTL_TRGEN_BIT];
        d.diffMode = pwdata[CTL_DIFF_BIT];
        d.startBit = pwdata[CTL_START_BIT];
      end else if (paddr == CHAN_ENABLE_OFS) begin
        d.chanEn  = pwdata[7:0];
        d.bandgap = pwdata[CHE_BGAP_BIT];
      end else if (paddr == COMPARE_OFS) begin
        d.cmpEn    = pwdata[CMP_EN_BIT];
        d.cmpIe    = pwdata[CMP_IE_BIT];
        d.cmpCond  = pwdata[CMP_COND_BIT];
        d.cmpCh    = pwdata[CMP_CH_LSB+:3];
        d.cmpCnt   = pwdata[CMP_CNT_LSB+:4];
        d.cmpVal   = pwdata[CMP_VAL_LSB+:RES_W];
        d.matchCnt = 4'h0;
      end else if (paddr == CONV_STATUS_OFS) begin
        d.endFlag = q.endFlag & ~pwdata[STS_END_BIT];
        d.cmpFlag = q.cmpFlag & ~pwdata[STS_CMP_BIT];
      end else if (paddr == CALIB_CONTROL_OFS && pwdata[CAL_EN_BIT]) begin
        d.calReq  = 1'b1;
        d.calDone = 1'b0;
      end else if (paddr == CLOCK_SOURCE_OFS) begin
        d.clock_source_reg = pwdata[1:0];
      end else if (paddr == CLOCK_DIVIDE_OFS) begin
        d.clock_divide_reg = pwdata[7:0];
      end
    end

    // Trigger pin only arms a sequence from idle
    if (q.trgEn && trigEdge && q.state == SAC_IDLE) begin
      d.startBit = 1'b1;
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    case (q.state)
      SAC_IDLE: begin
        if (q.calReq) begin
          d.state  = SAC_CAL;
          d.calCnt = 7'h00;
        end else if (q.startBit) begin
          if (!firstCh[3]) begin
            d.startBit = 1'b0;
          end else begin
            d.chan  = firstCh[2:0];
            d.state = SAC_REQ;
          end
        end
      end
      SAC_CAL: begin
        if (q.tick) begin
          d.calCnt = q.calCnt + 7'h01;
          if (q.calCnt == CAL_TICKS - 7'h01) begin
            d.state   = SAC_IDLE;
            d.calDone = 1'b1;
            d.calReq  = 1'b0;
          end
        end
      end
      SAC_REQ: begin
        if (!q.startBit) begin
          d.state = SAC_IDLE;
        end else if (q.tick) begin
          d.anaStart = 1'b1;
          d.state    = SAC_WAIT;
        end
      end
      SAC_WAIT: begin
        if (anaDone) begin
          // Stopping mid-scan still lets the running conversion land
          if (q.mode == SAC_BURST) begin
            if (d.fifoCnt != FIFO_DEPTH) begin
              d.fifo[q.fifoWr] = anaResult;
              d.fifoWr         = q.fifoWr + 3'h1;
              d.fifoCnt        = d.fifoCnt + 4'h1;
            end else begin
              d.fifoOvr = 1'b1;
            end
            if (d.fifoCnt > FIFO_FLAG_AT) begin
              d.endFlag = 1'b1;
            end
            d.state = q.startBit ? SAC_REQ : SAC_IDLE;
          end else begin
            d.resOvr[q.chan]   = d.resValid[q.chan];
            d.resValid[q.chan] = 1'b1;
            d.res[q.chan]      = anaResult;
            if (q.mode == SAC_SINGLE) begin
              d.endFlag  = 1'b1;
              d.startBit = 1'b0;
              d.state    = SAC_IDLE;
            end else if (nextCh[3]) begin
              d.chan  = nextCh[2:0];
              d.state = q.startBit ? SAC_REQ : SAC_IDLE;
            end else begin
              d.endFlag = 1'b1;
              if (q.mode == SAC_SSCAN) begin
                d.startBit = 1'b0;
                d.state    = SAC_IDLE;
              end else begin
                d.chan  = firstCh[2:0];
                d.state = q.startBit ? SAC_REQ : SAC_IDLE;
              end
            end
          end
          if (q.cmpEn && q.cmpCh == q.chan) begin
            if (!cmpMatch) begin
              d.matchCnt = 4'h0;
            end else if (cntInc == {1'b0, q.cmpCnt} + 5'h01) begin
              d.matchCnt = 4'h0;
              d.cmpFlag  = 1'b1;
            end else begin
              d.matchCnt = cntInc[3:0];
            end
          end
        end
      end
      default: d.state = SAC_IDLE;
    endcase

    d.calRun = d.state == SAC_CAL;
    d.irq = (q.endFlag & q.irqEn) | (q.cmpFlag & q.cmpIe);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign anaStart   = q.anaStart;
  assign anaChan    = q.chan;
  assign anaCalib   = q.calRun;
  assign anaDiff    = q.diffMode;
  assign anaBandgap = q.bandgap;
  assign convClkEn  = q.tick;
  assign convIrq    = q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_done_mode(logic [1:0] m);
    ce && doneEv && q.mode == m;
  endsequence

  sequence s_cal_last;
    ce && q.state == SAC_CAL && q.tick && q.calCnt == 7'h7e;
  endsequence

  a_single_end_flag: assert property (s_done_mode(SAC_SINGLE) |=> q.endFlag && !q.startBit)
    else $error("single conversion did not flag end and clear start");
  a_single_result: assert property (s_done_mode(SAC_SINGLE) |=>
      q.resValid[$past(q.chan)] && q.res[$past(q.chan)] == $past(anaResult))
    else $error("single result not stored in its channel");
  a_cal_done_time: assert property (s_cal_last |=> q.calDone && q.state == SAC_IDLE)
    else $error("calibration did not finish after its last tick");
  a_cal_done_src: assert property ($rose(q.calDone) |-> $past(q.calCnt) == 7'h7e)
    else $error("calibration done raised early");
  a_lowest_chan: assert property (ce && q.state == SAC_IDLE && q.startBit && !q.calReq &&
      firstCh[3] |=> q.chan == $past(firstCh[2:0]))
    else $error("sequence did not begin on lowest channel");
  a_scan_ascend: assert property ((s_done_mode(SAC_SSCAN) or s_done_mode(SAC_CSCAN)) ##0
      nextCh[3] |=> q.chan > $past(q.chan))
    else $error("scan order not ascending");
  a_burst_flag: assert property (s_done_mode(SAC_BURST) ##0 q.fifoCnt >= FIFO_FLAG_AT &&
      !(rdEn && paddr == RESULT0_OFS) |=> q.endFlag)
    else $error("burst flag missing with more than four samples");
  a_overrun_set: assert property ((s_done_mode(SAC_SINGLE) or s_done_mode(SAC_SSCAN)) ##0
      q.resValid[q.chan] && !rdEn |=> q.resOvr[$past(q.chan)])
    else $error("overrun not flagged on unread result");
  a_irq_follow: assert property (ce && q.endFlag && q.irqEn |=> convIrq)
    else $error("interrupt missing for enabled end flag");
  a_trig_arm: assert property (ce && q.trgEn && trigEdge && q.state == SAC_IDLE &&
      !q.calReq |=> q.startBit || q.state == SAC_REQ)
    else $error("trigger edge did not start a sequence");
  a_prescale_gap: assert property (ce && q.tick && q.clock_divide_reg != 8'h00 && !wrEn |=> !q.tick)
    else $error("prescaler ticked on consecutive cycles");
  a_burst_stop: assert property (s_done_mode(SAC_BURST) ##0 !q.startBit |=>
      q.state == SAC_IDLE)
    else $error("burst did not stop after start cleared");

endmodule

//--- tb/sac_ana_model.sv
module sac_ana_model
  import sac_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      anaStart,
  input  wire logic [2:0]                anaChan,
  input  wire logic [3:0]                lat,
  output logic                           anaDone,
  output logic      [sac_pkg::RES_W-1:0] anaResult
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic [2:0] chq;
  logic       busy;
  // ---------------------------------------------------------------
  // Analog core: one conversion at a time, latency set by the bench
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    anaDone <= 1'b0;
    // Result bus is garbage outside the done cycle so stale data is never trusted
    anaResult <= ~anaResult;
    if (rst) begin
      busy      <= 1'b0;
      anaResult <= '0;
    end else if (busy && cnt == 5'h00) begin
      busy      <= 1'b0;
      anaDone   <= 1'b1;
      anaResult <= {chq, 9'h0c3};
    end else if (busy) begin
      cnt <= cnt - 5'h01;
    end else if (anaStart) begin
      busy <= 1'b1;
      chq  <= anaChan;
      cnt  <= {1'b0, lat};
    end
  end
endmodule

//--- tb/test_sac_ctrl.sv
module test_sac_ctrl;
  import sac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ST  = 32'h1 << CTL_START_BIT;
  localparam logic [31:0] SGL = 32'(SAC_SINGLE) << CTL_MODE_LSB;
  localparam logic [31:0] BST = 32'(SAC_BURST) << CTL_MODE_LSB;
  localparam logic [31:0] SSC = 32'(SAC_SSCAN) << CTL_MODE_LSB;
  localparam logic [31:0] CSC = 32'(SAC_CSCAN) << CTL_MODE_LSB;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        extTrigPin = 1'b0;
  logic        extClkPin = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [31:0] prdata, rv;
  logic        pready, pslverr, anaDone, anaStart, anaCalib, anaDiff, anaBandgap;
  logic        convClkEn, convIrq;
  logic [2:0]  anaChan;
  logic [11:0] anaResult;
  logic [8:0]  en;
  logic [2:0]  q[$];
  int          e[$];
  int          num_errors = 0, num_checks = 0, cyc = 0, i, j, k, n, p;

  always #2.5 core_clk = ~core_clk;
  always #37 extClkPin = ~extClkPin;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (anaStart === 1'b1) q.push_back(anaChan);
  end

  sac_ctrl DUT (.core_clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .extTrigPin, .extClkPin, .anaDone, .anaResult,
    .anaStart, .anaChan, .anaCalib, .anaDiff, .anaBandgap, .convClkEn, .convIrq);
  sac_ana_model ana (.core_clk, .rst, .anaStart, .anaChan, .lat, .anaDone, .anaResult);

  // ---------------------------------------------------------------
  // Bus and checking helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic fail();
    num_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (t == 50) fail();
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  function automatic logic [31:0] res(input int ch);
    return 32'((ch << 9) | 12'h0c3);
  endfunction
  task automatic expect_seq(input logic [8:0] m);
    e = {};
    for (int c = 0; c < 8; c++) if (m[c]) e.push_back(c);
  endtask
  task automatic run(input logic [31:0] ctl, input logic [8:0] m);
    wr(CONV_CONTROL_OFS, ctl & ~ST);
    wr(CHAN_ENABLE_OFS, {23'h0, m});
    lat <= 4'($urandom_range(0, 9));
    q = {};
    wr(CONV_CONTROL_OFS, ctl);
  endtask
  task automatic waitq(input int m);
    int t;
    for (t = 0; t < 3000 && q.size() < m; t++) @(posedge core_clk);
    if (t == 3000) fail();
  endtask
  task automatic idle();
    int t;
    for (t = 0; t < 300; t++) begin
      rd(CONV_STATUS_OFS);
      if (rv[STS_BUSY_BIT] === 1'b0) break;
    end
    if (t == 300) fail();
  endtask
  task automatic calib();
    int t, c0;
    c0 = cyc;
    wr(CALIB_CONTROL_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(anaCalib, 1);
    for (t = 0; t < 600; t++) begin
      rd(CALIB_CONTROL_OFS);
      if (rv[1:0] === 2'b10) break;
    end
    chk({anaCalib, rv[1:0]}, 3'b010);
    // 127 ticks of 13 core cycles, first tick phase unknown
    chk(32'(cyc - c0 >= 1638 && cyc - c0 <= 1681), 1);
  endtask
  task automatic period(output int pp);
    int t, c0;
    // First tick may still come from the old setting
    for (int r = 0; r < 3; r++) begin
      for (t = 0; t < 600; t++) begin
        @(posedge core_clk);
        if (convClkEn === 1'b1) break;
      end
      if (t == 600) fail();
      if (r == 1) c0 = cyc;
    end
    pp = cyc - c0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(99));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(CONV_CONTROL_OFS);
    chk(rv, 0);
    rd(RESULT7_OFS);
    chk(rv, 0);
    apb(1'b0, 8'h2c, 32'h0);
    chk(rv, 0);
    chk(pslverr, 1);
    apb(1'b0, 8'h21, 32'h0);
    chk(pslverr, 1);
    // Source, divider, expected tick period in core cycles
    for (i = 0; i < 4; i++) begin
      wr(CLOCK_SOURCE_OFS, (i == 1) ? 32'h1 : (i == 3) ? 32'h2 : 32'h3 * (i / 2));
      wr(CLOCK_DIVIDE_OFS, (i >= 2) ? 32'h0 : 32'h2);
      period(p);
      // Pin edges every 74 ns land 14 or 15 core cycles apart
      if (i == 3) chk(32'(p >= 14 && p <= 15), 1);
      else chk(p, (i == 0) ? 3 : (i == 1) ? 6 : 1);
    end
    wr(CLOCK_SOURCE_OFS, 32'h0);
    wr(CLOCK_DIVIDE_OFS, 32'h0c);
    calib();
    $display("test clock and calibration done");
    for (i = 0; i < 3; i++) begin
      en = 9'($urandom_range(1, 255));
      expect_seq(en);
      // Two runs without a read in between force an overrun
      for (j = 0; j < 2; j++) begin
        run(SGL | (32'h1 << CTL_IRQEN_BIT) | ST, en);
        waitq(1);
        idle();
        chk(q.size(), 1);
        chk({29'h0, q[0]}, e[0]);
      end
      rd(CONV_CONTROL_OFS);
      chk(rv[CTL_START_BIT], 0);
      rd(CONV_STATUS_OFS);
      chk({rv[STS_END_BIT], convIrq}, 2'b11);
      rd(RESULT0_OFS + 8'(4 * e[0]));
      chk(rv, res(e[0]) | (32'h3 << RES_OVR_BIT));
      rd(RESULT0_OFS + 8'(4 * e[0]));
      chk(rv[17:16], 0);
      wr(CONV_STATUS_OFS, 32'h1);
      rd(CONV_STATUS_OFS);
      chk({rv[STS_END_BIT], convIrq}, 2'b00);
    end
    $display("test single mode done");
    for (j = 0; j < 2; j++) begin
      en = j ? 9'h0ff : 9'($urandom_range(1, 255));
      expect_seq(j ? 9'h00f : en);
      wr(CONV_CONTROL_OFS, 32'(j) << CTL_DIFF_BIT);
      if (j) calib();
      chk(anaDiff, j);
      run(SSC | (32'(j) << CTL_DIFF_BIT) | ST, en);
      waitq(e.size());
      idle();
      chk(q.size(), e.size());
      foreach (e[c]) begin
        chk({29'h0, q[c]}, e[c]);
        rd(RESULT0_OFS + 8'(4 * e[c]));
        chk(rv, res(e[c]) | (32'h1 << RES_VALID_BIT));
      end
    end
    wr(CONV_CONTROL_OFS, 32'h0);
    calib();
    wr(CONV_STATUS_OFS, 32'h3);
    en = 9'($urandom_range(1, 255));
    expect_seq(en);
    n = e.size();
    run(CSC | ST, en);
    waitq(3 * n);
    wr(CONV_CONTROL_OFS, CSC);
    idle();
    for (k = 0; k < q.size(); k++) chk({29'h0, q[k]}, e[k % n]);
    rd(CONV_STATUS_OFS);
    chk(rv[STS_END_BIT], 1);
    $display("test scan modes done");
    wr(CONV_STATUS_OFS, 32'h3);
    run(BST | ST, 9'h030);
    waitq(12);
    wr(CONV_CONTROL_OFS, BST);
    idle();
    for (k = 0; k < q.size(); k++) chk({29'h0, q[k]}, 4);
    rd(CONV_STATUS_OFS);
    chk({rv[STS_FCNT_LSB +: 4], rv[STS_END_BIT]}, 5'h11);
    for (k = 0; k < 8; k++) begin
      rd(RESULT0_OFS);
      chk({rv[RES_VALID_BIT], rv[11:0]}, res(4) | 32'h1000);
    end
    rd(RESULT0_OFS);
    chk(rv[RES_VALID_BIT], 0);
    $display("test burst mode done");
    for (j = 0; j < 2; j++) begin
      wr(CONV_STATUS_OFS, 32'h3);
      wr(COMPARE_OFS, 32'h3 | (32'(j) << CMP_COND_BIT) | (32'h3 << CMP_CH_LSB)
         | (res(3) << CMP_VAL_LSB));
      run(SGL | ST, 9'h008);
      waitq(1);
      idle();
      rd(CONV_STATUS_OFS);
      chk({rv[STS_CMP_BIT], convIrq}, j ? 2'b11 : 2'b00);
    end
    wr(COMPARE_OFS, 32'h0);
    wr(CONV_STATUS_OFS, 32'h3);
    run(SGL | (32'h1 << CTL_TRGEN_BIT) | (32'h1 << CTL_TRGC_LSB), 9'h002);
    extTrigPin <= 1'b1;
    repeat (8) @(posedge core_clk);
    extTrigPin <= 1'b0;
    waitq(1);
    idle();
    chk({29'h0, q[0]}, 1);
    wr(CONV_CONTROL_OFS, 32'h0);
    for (j = 0; j < 2; j++) begin
      wr(CHAN_ENABLE_OFS, 32'(j) << CHE_BGAP_BIT);
      repeat (2) @(posedge core_clk);
      chk(anaBandgap, j);
    end
    $display("test compare, trigger and bandgap done");
    tally_and_finish();
  end
endmodule
